// *** hw/qpd_core.sv ***
/*
  Quad-phase instruction sequencer and executor for add-with-carry and
  compare-skip file-register instructions. Holds the working register and
  carry; the file register array is external and reached through a read
  address, read data and a write strobe.
  Assumes program memory presents the instruction word on insn_i and the
  file value on file_rdata_i, both synchronous to clk_sys_i; file_rdata_i
  must answer the address on file_addr_o within the read phase.
*/
`timescale 1ns/1ns
`default_nettype none
module qpd_core (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [15:0] insn_i,
  input  wire logic [7:0]  file_rdata_i,
  output var  logic [3:0]  phase_o,
  output var  logic        insn_fetch_o,
  output var  logic [7:0]  file_addr_o,
  output var  logic [7:0]  file_wdata_o,
  output var  logic        file_we_o,
  output var  logic [7:0]  working_register_o,
  output var  logic        carry_o,
  output var  logic        forced_nop_o,
  output var  logic        skip_taken_o
);
  qpd_pkg::qpd_phase_t phase_q;
  qpd_pkg::qpd_phase_t phase_d;
  logic [15:0] opcode_q;
  logic [7:0]  fval_q;
  logic [7:0]  result_q;
  logic        carry_res_q;
  logic        skip_pend_q;
  logic        nop_q;
  logic [7:0]  working_register_q;
  logic        carry_q;
  logic        file_we_q;
  logic        fetch_q;
  logic        skip_q;

  qpd_dec_if dif ();

  // Next values, one per register
  wire [15:0] opcode_d;
  wire [7:0]  fval_d;
  wire [7:0]  result_d;
  wire        carry_res_d;
  wire        skip_pend_d;
  wire        nop_d;
  wire [7:0]  working_register_d;
  wire        carry_d;
  wire        file_we_d;
  wire        fetch_d;
  wire        skip_d;

  // Phase strobes, op matches and datapath nets
  wire       at_decode_w;
  wire       at_read_w;
  wire       at_process_w;
  wire       at_write_w;
  wire       is_addc_w;
  wire       is_cpgt_w;
  wire       is_cplt_w;
  wire [8:0] chain_w;
  wire [7:0] sum_bits_w;
  wire [8:0] sum_w;
  wire       gt_w;
  wire       lt_w;
  wire       skip_w;
  wire       live_w;
  wire       addc_live_w;
  wire       to_working_register_w;
  wire       to_file_w;

  assign dif.opcode = opcode_q;

  qpd_opdec u_dec (
    .d (dif)
  );

  // Phase advance, one step per oscillator period
  always_comb begin
    unique case (phase_q)
      qpd_pkg::QPD_PH_DECODE:  phase_d = qpd_pkg::QPD_PH_READ;
      qpd_pkg::QPD_PH_READ:    phase_d = qpd_pkg::QPD_PH_PROCESS;
      qpd_pkg::QPD_PH_PROCESS: phase_d = qpd_pkg::QPD_PH_WRITE;
      qpd_pkg::QPD_PH_WRITE:   phase_d = qpd_pkg::QPD_PH_DECODE;
      default:                 phase_d = qpd_pkg::QPD_PH_DECODE;
    endcase
  end

  // Which phase the next enabled edge closes
  assign at_decode_w  = phase_q == qpd_pkg::QPD_PH_DECODE;
  assign at_read_w    = phase_q == qpd_pkg::QPD_PH_READ;
  assign at_process_w = phase_q == qpd_pkg::QPD_PH_PROCESS;
  assign at_write_w   = phase_q == qpd_pkg::QPD_PH_WRITE;

  // Operation class from the decoder
  assign is_addc_w = dif.op == qpd_pkg::QPD_OP_ADDC;
  assign is_cpgt_w = dif.op == qpd_pkg::QPD_OP_CPGT;
  assign is_cplt_w = dif.op == qpd_pkg::QPD_OP_CPLT;

  // Ripple adder, one stage per bit; carry in is the stored carry
  // Bit 8 of the chain is the carry out kept for the write phase
  assign chain_w[0] = carry_q;
  for (genvar b = 0; b < qpd_pkg::DATA_W; b++) begin : g_add
    assign sum_bits_w[b] = working_register_q[b] ^ fval_q[b] ^ chain_w[b];
    assign chain_w[b+1]  = (working_register_q[b] & fval_q[b]) | (chain_w[b] & (working_register_q[b] ^ fval_q[b]));
  end
  assign sum_w = {chain_w[8], sum_bits_w};

  // Unsigned compares; no flag is touched
  assign gt_w   = fval_q > working_register_q;
  assign lt_w   = fval_q < working_register_q;
  assign skip_w = (is_cpgt_w && gt_w) ||
                  (is_cplt_w && lt_w);
  assign live_w = !nop_q;

  // Decode: a pending skip swaps the offered word for a no-operation
  // The ignored word still shows on insn_i; only the latch drops it
  assign opcode_d    = !at_decode_w ? opcode_q :
                       skip_pend_q  ? qpd_pkg::NOP_WORD :
                                      insn_i;
  assign nop_d       = at_decode_w ? skip_pend_q : nop_q;
  // Read: a file write from the previous slot has landed by now
  assign fval_d      = at_read_w ? file_rdata_i : fval_q;
  // Process: sum and carry held until write; skip raised here
  assign result_d    = at_process_w ? sum_w[7:0] : result_q;
  assign carry_res_d = at_process_w ? sum_w[8] : carry_res_q;
  assign skip_d      = at_process_w && live_w && skip_w;
  assign skip_pend_d = skip_d || (skip_pend_q && !at_decode_w);
  // Write: an add commits to exactly one destination
  assign addc_live_w = at_write_w && live_w && is_addc_w;
  assign to_working_register_w   = addc_live_w && (dif.dest_file == qpd_pkg::DEST_WORKING_REGISTER);
  assign to_file_w   = addc_live_w && (dif.dest_file != qpd_pkg::DEST_WORKING_REGISTER);
  assign working_register_d      = to_working_register_w ? result_q : working_register_q;
  assign carry_d     = addc_live_w ? carry_res_q : carry_q;
  assign file_we_d   = to_file_w;
  assign fetch_d     = at_write_w;

  // Phase register; the clock enable stands in for one oscillator tick
  // Reset lands in decode so the first enabled edge takes a word
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      phase_q <= qpd_pkg::QPD_PH_DECODE;
    end else if (ce_i) begin
      phase_q <= phase_d;
    end
  end

  // Instruction latch and skip bookkeeping
  // The pending skip is only ever cleared in decode, never set there
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      opcode_q    <= qpd_pkg::NOP_WORD;
      nop_q       <= 1'b0;
      skip_pend_q <= 1'b0;
    end else if (ce_i) begin
      opcode_q    <= opcode_d;
      nop_q       <= nop_d;
      skip_pend_q <= skip_pend_d;
    end
  end

  // Operand and result latches
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fval_q      <= 8'h00;
      result_q    <= 8'h00;
      carry_res_q <= 1'b0;
    end else if (ce_i) begin
      fval_q      <= fval_d;
      result_q    <= result_d;
      carry_res_q <= carry_res_d;
    end
  end

  // Working register and carry; only a live add moves them
  // Compares never reach this block, so the carry survives them
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      working_register_q  <= qpd_pkg::WORKING_REGISTER_RESET;
      carry_q <= 1'b0;
    end else if (ce_i) begin
      working_register_q  <= working_register_d;
      carry_q <= carry_d;
    end
  end

  // One-cycle strobes, cleared on every enabled edge
  // A frozen clock enable stretches them along with the phase
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      file_we_q <= 1'b0;
      fetch_q   <= 1'b0;
      skip_q    <= 1'b0;
    end else if (ce_i) begin
      file_we_q <= file_we_d;
      fetch_q   <= fetch_d;
      skip_q    <= skip_d;
    end
  end

  // Registered outputs; the file address is the latched opcode's low byte
  assign phase_o            = phase_q;
  assign insn_fetch_o       = fetch_q;
  assign file_addr_o        = dif.faddr;
  assign file_wdata_o       = result_q;
  assign file_we_o          = file_we_q;
  assign working_register_o = working_register_q;
  assign carry_o            = carry_q;
  assign forced_nop_o       = nop_q;
  assign skip_taken_o       = skip_q;
endmodule
`default_nettype wire

// *** hw/qpd_pkg.sv ***
/*
  Package for the quad-phase instruction decoder: phase encodings, opcode
  fields and timing constants.
  Assumes a single system clock at 10 MHz acting as the device oscillator.
*/
package qpd_pkg;

  // Phase state, one-hot
  typedef enum logic [3:0] {
    QPD_PH_DECODE  = 4'b0001,
    QPD_PH_READ    = 4'b0010,
    QPD_PH_PROCESS = 4'b0100,
    QPD_PH_WRITE   = 4'b1000
  } qpd_phase_t;

  // Operation class decoded from the upper opcode byte
  typedef enum logic [1:0] {
    QPD_OP_NONE = 2'h0,
    QPD_OP_ADDC = 2'h1,
    QPD_OP_CPGT = 2'h2,
    QPD_OP_CPLT = 2'h3
  } qpd_op_t;

  // Opcode field layout
  localparam int          OPC_W        = 16;
  localparam int          DATA_W       = 8;
  localparam int          HI_MSB       = 15;
  localparam int          HI_LSB       = 8;
  localparam int          ADDC_MSB     = 15;
  localparam int          ADDC_LSB     = 9;
  localparam int          DEST_BIT     = 8;
  localparam logic [6:0]  ADDC_PATTERN = 7'h08;     // 0001 000d
  localparam logic [7:0]  CPGT_PATTERN = 8'h32;     // 0011 0010
  localparam logic [7:0]  CPLT_PATTERN = 8'h30;     // 0011 0000
  localparam logic        DEST_WORKING_REGISTER    = 1'b0;

  // Reset values
  localparam logic [7:0]  WORKING_REGISTER_RESET   = 8'h00;
  localparam logic [15:0] NOP_WORD     = 16'h0000;

  // Timing: one phase is one oscillator period
  localparam int          CLK_PERIOD_NS   = 100;
  localparam int          OSC_PERIOD_NS   = 100;
  localparam int          PHASE_CYCLES    = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PHASES_PER_INSN = 4;

endpackage

// *** hw/qpd_dec_if.sv ***
/*
  Interface carrying the decode result from the opcode decoder to the
  sequencer inside the instruction decoder.
  Assumes both ends are in the same clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
interface qpd_dec_if;
  logic [15:0]      opcode;
  qpd_pkg::qpd_op_t op;
  logic             dest_file;
  logic [7:0]       faddr;

  modport dec (input opcode, output op, output dest_file, output faddr);
  modport seq (output opcode, input op, input dest_file, input faddr);
endinterface
`default_nettype wire

// *** hw/qpd_opdec.sv ***
/*
  Combinational opcode decoder for the add-with-carry and compare-skip
  instructions.
  Assumes the opcode on the interface is stable during the decode phase.
*/
`timescale 1ns/1ns
`default_nettype none
module qpd_opdec (
  qpd_dec_if.dec d
);
  wire [7:0] hi_byte;
  wire       is_addc;
  wire       is_cpgt;
  wire       is_cplt;

  // Field match on the upper byte
  assign hi_byte = d.opcode[qpd_pkg::HI_MSB:qpd_pkg::HI_LSB];
  assign is_addc = d.opcode[qpd_pkg::ADDC_MSB:qpd_pkg::ADDC_LSB] == qpd_pkg::ADDC_PATTERN;
  assign is_cpgt = hi_byte == qpd_pkg::CPGT_PATTERN;
  assign is_cplt = hi_byte == qpd_pkg::CPLT_PATTERN;

  // Operation select and destination
  assign d.op = is_addc ? qpd_pkg::QPD_OP_ADDC :
                is_cpgt ? qpd_pkg::QPD_OP_CPGT :
                is_cplt ? qpd_pkg::QPD_OP_CPLT : qpd_pkg::QPD_OP_NONE;
  assign d.dest_file = d.opcode[qpd_pkg::DEST_BIT];
  assign d.faddr     = d.opcode[7:0];
endmodule
`default_nettype wire

// *** tb/qpd_core_checker.sv ***
/* Checker on the ports of qpd_core: phase order, strobes and skip slots.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ns
`default_nettype none
module qpd_core_checker (
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  input wire logic       ce_i,
  input wire logic [3:0] phase_o,
  input wire logic       insn_fetch_o,
  input wire logic       file_we_o,
  input wire logic [7:0] working_register_o,
  input wire logic       forced_nop_o,
  input wire logic       skip_taken_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Skip flagged, then a whole slot of no-operation
  sequence s_skip; skip_taken_o && ce_i; endsequence
  sequence s_nop_slot; forced_nop_o [*4]; endsequence
  a_phase_onehot: assert property ($onehot(phase_o)) else $error("phase not one-hot");
  a_phase_rotate: assert property (ce_i |=> phase_o == {$past(phase_o[2:0]), $past(phase_o[3])})
    else $error("phase order broken");
  a_phase_freeze: assert property (!ce_i |=> $stable(phase_o)) else $error("phase moved");
  a_fetch_decode: assert property (insn_fetch_o |-> phase_o == 4'h1) else $error("fetch off");
  a_we_decode: assert property (file_we_o |-> phase_o == 4'h1 && !forced_nop_o)
    else $error("write strobe off");
  a_skip_write: assert property (skip_taken_o |-> phase_o == 4'h8) else $error("skip off");
  a_skip_nop: assert property (s_skip ##1 ce_i |=> s_nop_slot) else $error("no forced nop");
  a_nop_keeps: assert property (forced_nop_o && ce_i && phase_o == 4'h8 |=>
    $stable(working_register_o)) else $error("nop changed working_register");
endmodule
bind qpd_core qpd_core_checker chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
  .phase_o(phase_o), .insn_fetch_o(insn_fetch_o), .file_we_o(file_we_o),
  .working_register_o(working_register_o), .forced_nop_o(forced_nop_o),
  .skip_taken_o(skip_taken_o));
`default_nettype wire

// *** tb/qpd_pmem.sv ***
/* Partner model: file register array behind the core's address.
   Assumes writes arrive on file_we_i at a rising edge. */
`timescale 1ns/1ns
`default_nettype none
module qpd_pmem (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] file_addr_i,
  input  wire logic [7:0] file_wdata_i,
  input  wire logic       file_we_i,
  output wire logic [7:0] file_rdata_o
);
  logic [7:0] mem [256];
  // Each location starts holding its own address
  initial for (int i = 0; i < 256; i++) mem[i] = i[7:0];
  // Store add results aimed at the file
  always @(posedge clk_sys_i) if (file_we_i) mem[file_addr_i] <= file_wdata_i;
  assign file_rdata_o = mem[file_addr_i];
endmodule
`default_nettype wire

// *** tb/tb.sv ***
/* Testbench for qpd_core: add with carry, compare-skip, clock enable.
   Assumes qpd_pmem as the file register side. */
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        ce_i      = 1'b1;
  logic [15:0] insn_i    = 16'h0000;
  logic [7:0]  rdata, faddr, wdata, working_register;
  logic [3:0]  phase;
  logic        we, carry, nop;
  int          miscompares = 0;
  int          n_checks    = 0;
  qpd_core dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .insn_i(insn_i),
    .file_rdata_i(rdata), .phase_o(phase), .insn_fetch_o(), .file_addr_o(faddr),
    .file_wdata_o(wdata), .file_we_o(we), .working_register_o(working_register), .carry_o(carry),
    .forced_nop_o(nop), .skip_taken_o());
  qpd_pmem pm (.clk_sys_i(clk_sys_i), .file_addr_i(faddr), .file_wdata_i(wdata),
    .file_we_i(we), .file_rdata_o(rdata));
  // Clock, 100 ns period
  initial forever #50 clk_sys_i = ~clk_sys_i;
  task automatic chk(input logic [8:0] seen, input logic [8:0] want);
    n_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Offer a word in the decode phase, bounded wait
  task automatic issue(input logic [15:0] w);
    int n;
    n = 0;
    while (phase !== 4'h1) begin
      @(negedge clk_sys_i);
      n++;
      if (n > 20) begin
        miscompares++;
        close_out();
      end
    end
    insn_i = w;
    @(negedge clk_sys_i);
  endtask
  // Add into working register, carry out then carry in
  task automatic t_add_working_register;
    issue(16'h1010);
    issue(16'h10F8);
    chk({carry, working_register}, 9'h010);
    issue(16'h1001);
    chk({carry, working_register}, 9'h108);
    issue(16'h0000);
    chk({carry, working_register}, 9'h00A);
    $display("t_add_working_register done");
  endtask
  // Add into file register, then read it back
  task automatic t_add_file;
    issue(16'h1120);
    issue(16'h1020);
    chk({carry, working_register}, 9'h00A);
    issue(16'h0000);
    chk({carry, working_register}, 9'h034);
    $display("t_add_file done");
  endtask
  // Compares with and without skip; next add lands only without
  task automatic t_skip;
    logic [15:0] ops [4] = '{16'h3240, 16'h3010, 16'h3210, 16'h3040};
    logic [7:0]  want [4] = '{8'h34, 8'h34, 8'h35, 8'h36};
    logic        skips [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 4; i++) begin
      issue(ops[i]);
      issue(16'h1001);
      chk({8'h00, nop}, {8'h00, skips[i]});
      issue(16'h0000);
      issue(16'h0000);
      chk({carry, working_register}, {1'b0, want[i]});
    end
    $display("t_skip done");
  endtask
  // Clock enable low holds the phase
  task automatic t_freeze;
    issue(16'h0000);
    chk({5'h00, phase}, 9'h002);
    ce_i = 1'b0;
    repeat (5) @(negedge clk_sys_i);
    chk({5'h00, phase}, 9'h002);
    ce_i = 1'b1;
    @(negedge clk_sys_i);
    chk({5'h00, phase}, 9'h004);
    $display("t_freeze done");
  endtask
  initial begin
    repeat (6) @(negedge clk_sys_i);
    rst_i = 1'b0;
    t_add_working_register();
    t_add_file();
    t_skip();
    t_freeze();
    close_out();
  end
endmodule
`default_nettype wire
